// File: hw/rco_pkg.sv
`default_nettype none
package rco_pkg;
  // register map (printed offset 0x17 is not a multiple of four: index, byte address is 4x)
  localparam logic [7:0]  CTRL_INDEX      = 8'h17;
  localparam logic [11:0] CTRL_BYTE_ADDR  = {2'b00, CTRL_INDEX, 2'b00};
  localparam logic [7:0]  STAT_INDEX      = 8'h18;
  localparam logic [11:0] STAT_BYTE_ADDR  = {2'b00, STAT_INDEX, 2'b00};
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK    = 16'hFF37;
  // control field positions
  localparam int EN_BIT   = 15;
  localparam int SRC_LSB  = 11;
  localparam int FRQ_LSB  = 8;
  localparam int SQL_LSB  = 4;
  localparam int TYP_LSB  = 0;
  // codes
  localparam logic [3:0] SRC_MAX      = 4'h3;
  localparam logic [2:0] FRQ_25       = 3'h0;
  localparam logic [2:0] FRQ_125      = 3'h1;
  localparam logic [2:0] FRQ_31P25    = 3'h2;
  localparam logic [2:0] TYP_MAX      = 3'h2;
  localparam logic [1:0] SQL_AUTO     = 2'h0;
  localparam logic [1:0] SQL_RELAXED  = 2'h1;
  localparam logic [1:0] SQL_LINK     = 2'h2;
  localparam logic [1:0] SQL_OFF      = 2'h3;
  // divider: selected source clock is a 125 MHz sampled reference
  localparam logic [2:0] DIV_125      = 3'h0;
  localparam logic [2:0] DIV_25       = 3'h4;
  localparam logic [2:0] DIV_31P25    = 3'h3;
  // link mode codes per port
  typedef enum logic [2:0] {
    RCO_M_10, RCO_M_100, RCO_M_1000_MST, RCO_M_1000_SLV, RCO_M_OTHER
  } rco_mode_t;
endpackage
`default_nettype wire

// File: hw/rco_if.sv
`default_nettype none
interface rco_if;
  logic       clk_in;
  logic [2:0] div_code;
  logic       run;
  logic       clk_out;
  modport ctrl (output div_code, output run, output clk_in, input clk_out);
  modport div  (input div_code, input run, input clk_in, output clk_out);
endinterface
`default_nettype wire

// File: hw/rco_divider.sv
`default_nettype none
module rco_divider (
  input  wire logic CORE_CLK,
  input  wire logic RESETN,
  rco_if.div        bus
);
  typedef struct packed {
    logic       prev_reg;
    logic [2:0] cnt_reg;
    logic       out_reg;
  } rco_div_st_t;
  rco_div_st_t st_reg;
  rco_div_st_t st_next;
  logic        rise;
  assign rise = bus.clk_in & ~st_reg.prev_reg;
  // toggle out every half-period count of source rising edges; DIV_125 makes out follow the source directly
  always_comb begin
    st_next          = st_reg;
    st_next.prev_reg = bus.clk_in;
    if (!bus.run) begin
      st_next.cnt_reg = 3'h0;
      st_next.out_reg = 1'b0;
    end else if (bus.div_code == rco_pkg::DIV_125) begin
      st_next.out_reg = bus.clk_in;
    end else if (rise) begin
      if (st_reg.cnt_reg >= bus.div_code) begin
        st_next.cnt_reg = 3'h0;
        st_next.out_reg = ~st_reg.out_reg;
      end else begin
        st_next.cnt_reg = st_reg.cnt_reg + 3'h1;
      end
    end
  end
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign bus.clk_out = st_reg.out_reg;
endmodule
`default_nettype wire

// File: hw/rco_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module rco_top (
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [3:0]  SERDES_RECOVERED_CLOCK,
  input  wire logic [3:0]  COPPER_RECOVERED_CLOCK,
  input  wire logic [3:0]  COPPER_TRANSMIT_CLOCK,
  input  wire logic [3:0]  LINK_UP,
  input  wire logic [3:0]  LINK_STABLE,
  input  wire logic [11:0] LINK_MODE,
  input  wire logic [3:0]  EEE_ACTIVE,
  input  wire logic [3:0]  LP_IDLE_RX,
  input  wire logic        CLOCK_SQUELCH_IN,
  output logic             RECOVERED_CLOCK_ONE_OUTPUT
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0] ctrl_reg;
    logic        aw_reg;
    logic [11:0] awaddr_reg;
    logic        w_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [2:0]  sq1_reg;
    logic [2:0]  sq2_reg;
    logic [2:0]  sq3_reg;
    logic        sq_reg;
    logic        gate_reg;
  } rco_st_t;
  rco_st_t st_reg;
  rco_st_t st_next;

  logic [3:0]          src;
  logic [2:0]          frq;
  logic [1:0]          sql;
  logic [2:0]          typ;
  logic [1:0]          port;
  logic                codes_ok;
  logic                sel_clk;
  logic                link_ok;
  rco_pkg::rco_mode_t  mode;
  logic                pass_sql;
  logic                gate_now;
  logic                aw_hs;
  logic                w_hs;
  logic                ar_hs;
  logic [2:0]          sync_in;
  rco_if               dv ();

  function automatic logic [2:0] div_of(input logic [2:0] f);
    case (f)
      rco_pkg::FRQ_125:   div_of = rco_pkg::DIV_125;
      rco_pkg::FRQ_31P25: div_of = rco_pkg::DIV_31P25;
      default:            div_of = rco_pkg::DIV_25;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  assign src      = st_reg.ctrl_reg[rco_pkg::SRC_LSB +: 4];
  assign frq      = st_reg.ctrl_reg[rco_pkg::FRQ_LSB +: 3];
  assign sql      = st_reg.ctrl_reg[rco_pkg::SQL_LSB +: 2];
  assign typ      = st_reg.ctrl_reg[rco_pkg::TYP_LSB +: 3];
  assign port     = src[1:0];
  assign codes_ok = (src <= rco_pkg::SRC_MAX) && (frq <= rco_pkg::FRQ_31P25)
                    && (typ <= rco_pkg::TYP_MAX);
  assign mode     = rco_pkg::rco_mode_t'(LINK_MODE[3 * port +: 3]);
  assign link_ok  = LINK_UP[port] & LINK_STABLE[port];
  // the reclock paths are modelled as sampled levels on the core clock
  always_comb begin
    case (typ)
      3'h0:    sel_clk = SERDES_RECOVERED_CLOCK[port];
      3'h1:    sel_clk = COPPER_RECOVERED_CLOCK[port];
      default: sel_clk = COPPER_TRANSMIT_CLOCK[port];
    endcase
  end
  assign sync_in = {CLOCK_SQUELCH_IN, LINK_UP[port], sel_clk};

  always_comb begin
    case (sql)
      rco_pkg::SQL_AUTO: begin
        pass_sql = link_ok && !EEE_ACTIVE[port]
                   && (mode != rco_pkg::RCO_M_1000_MST) && (mode != rco_pkg::RCO_M_10);
      end
      rco_pkg::SQL_RELAXED: begin
        pass_sql = link_ok && (!EEE_ACTIVE[port] || LP_IDLE_RX[port]);
      end
      rco_pkg::SQL_LINK: pass_sql = st_reg.sq3_reg[1];
      default:           pass_sql = 1'b1;
    endcase
  end
  assign gate_now = st_reg.ctrl_reg[rco_pkg::EN_BIT] && codes_ok && pass_sql
                    && !st_reg.sq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  assign aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_hs  = S_AXI_WVALID & S_AXI_WREADY;
  assign ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  assign S_AXI_AWREADY = !st_reg.aw_reg && !st_reg.bvalid_reg;
  assign S_AXI_WREADY  = !st_reg.w_reg && !st_reg.bvalid_reg;
  assign S_AXI_ARREADY = !st_reg.rvalid_reg;

  always_comb begin
    st_next         = st_reg;
    st_next.sq1_reg = sync_in;
    st_next.sq2_reg = st_reg.sq1_reg;
    st_next.sq3_reg = st_reg.sq2_reg;
    if (st_reg.sq2_reg[2] == st_reg.sq3_reg[2]) begin
      st_next.sq_reg = st_reg.sq3_reg[2];
    end
    st_next.gate_reg = gate_now;
    if (aw_hs) begin
      st_next.aw_reg     = 1'b1;
      st_next.awaddr_reg = S_AXI_AWADDR;
    end
    if (w_hs) begin
      st_next.w_reg     = 1'b1;
      st_next.wdata_reg = S_AXI_WDATA;
      st_next.wstrb_reg = S_AXI_WSTRB;
    end
    if (st_reg.aw_reg && st_reg.w_reg) begin
      st_next.aw_reg     = 1'b0;
      st_next.w_reg      = 1'b0;
      st_next.bvalid_reg = 1'b1;
      st_next.bresp_reg  = 2'b10;
      if ({st_reg.awaddr_reg[11:2], 2'b00} == rco_pkg::CTRL_BYTE_ADDR) begin
        st_next.bresp_reg = 2'b00;
        for (int i = 0; i < 2; i++) begin
          if (st_reg.wstrb_reg[i]) begin
            st_next.ctrl_reg[8*i +: 8] = st_reg.wdata_reg[8*i +: 8] & rco_pkg::CTRL_WR_MASK[8*i +: 8];
          end
        end
      end else if ({st_reg.awaddr_reg[11:2], 2'b00} == rco_pkg::STAT_BYTE_ADDR) begin
        st_next.bresp_reg = 2'b00;
      end
    end else if (st_reg.bvalid_reg && S_AXI_BREADY) begin
      st_next.bvalid_reg = 1'b0;
    end
    if (ar_hs) begin
      st_next.rvalid_reg = 1'b1;
      st_next.rresp_reg  = 2'b00;
      st_next.rdata_reg  = 32'h0000_0000;
      if ({S_AXI_ARADDR[11:2], 2'b00} == rco_pkg::CTRL_BYTE_ADDR) begin
        st_next.rdata_reg = {16'h0000, st_reg.ctrl_reg};
      end else if ({S_AXI_ARADDR[11:2], 2'b00} == rco_pkg::STAT_BYTE_ADDR) begin
        st_next.rdata_reg = {29'h0000_0000, st_reg.sq_reg, codes_ok, st_reg.gate_reg};
      end else begin
        st_next.rresp_reg = 2'b10;
      end
    end else if (st_reg.rvalid_reg && S_AXI_RREADY) begin
      st_next.rvalid_reg = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg          <= '0;
      st_reg.ctrl_reg <= rco_pkg::CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign S_AXI_BVALID = st_reg.bvalid_reg;
  assign S_AXI_BRESP  = st_reg.bresp_reg;
  assign S_AXI_RVALID = st_reg.rvalid_reg;
  assign S_AXI_RDATA  = st_reg.rdata_reg;
  assign S_AXI_RRESP  = st_reg.rresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  assign dv.clk_in   = st_reg.sq3_reg[0];
  assign dv.div_code = div_of(frq);
  assign dv.run      = st_reg.gate_reg;
  rco_divider u_div (
    .CORE_CLK (CORE_CLK),
    .RESETN   (RESETN),
    .bus      (dv.div)
  );
  assign RECOVERED_CLOCK_ONE_OUTPUT = dv.clk_out & st_reg.gate_reg;

  ////////////////////////////////////////////////////////////////////////////////
  en_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !st_reg.ctrl_reg[rco_pkg::EN_BIT] |=> !RECOVERED_CLOCK_ONE_OUTPUT)
    else $error("output active while disabled");
  src_rsv_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (src > rco_pkg::SRC_MAX) |=> !st_reg.gate_reg)
    else $error("reserved source passed clock");
  frq_rsv_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (frq > rco_pkg::FRQ_31P25) |=> !st_reg.gate_reg)
    else $error("reserved frequency passed clock");
  auto_sq_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (sql == rco_pkg::SQL_AUTO && EEE_ACTIVE[port]) |=> !st_reg.gate_reg)
    else $error("eee not squelched");
  relax_sq_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (sql == rco_pkg::SQL_RELAXED && !link_ok) |=> !st_reg.gate_reg)
    else $error("level 01 passed with link bad");
  link_sq_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (sql == rco_pkg::SQL_LINK && st_reg.ctrl_reg[rco_pkg::EN_BIT] && codes_ok
     && !st_reg.sq_reg && st_reg.sq3_reg[1]) |=> st_reg.gate_reg)
    else $error("level 10 squelched with link up");
  no_sq_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (sql == rco_pkg::SQL_OFF && st_reg.ctrl_reg[rco_pkg::EN_BIT] && codes_ok
     && !st_reg.sq_reg) |=> st_reg.gate_reg)
    else $error("level 11 squelched");
  // three sync stages, agreement of the last two, then the gate register: low from the fifth edge on
  sequence pin_held_s;
    CLOCK_SQUELCH_IN [*5];
  endsequence
  sequence out_low_s;
    !RECOVERED_CLOCK_ONE_OUTPUT [*2];
  endsequence
  pin_sq_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    pin_held_s |=> out_low_s)
    else $error("squelch pin ignored");
  typ_rsv_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (typ > rco_pkg::TYP_MAX) |=> !st_reg.gate_reg)
    else $error("reserved clock type passed");
endmodule
`default_nettype wire

// File: sim/rco_phy_model.sv
`default_nettype none
module rco_phy_model (
  input  wire logic       clk,
  input  wire logic [1:0] port,
  input  wire logic [1:0] kind,
  output logic      [3:0] serdes_clk,
  output logic      [3:0] copper_rx_clk,
  output logic      [3:0] copper_tx_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tick = 1'b0;
  always @(posedge clk) tick <= ~tick;
  // only the chosen source runs, so a wrong port or type pick leaves the output silent
  always_comb begin
    serdes_clk    = (kind == 2'h0) ? (4'(tick) << port) : 4'h0;
    copper_rx_clk = (kind == 2'h1) ? (4'(tick) << port) : 4'h0;
    copper_tx_clk = (kind == 2'h2) ? (4'(tick) << port) : 4'h0;
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] CTRL = rco_pkg::CTRL_BYTE_ADDR;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  up = 4'h0, stb = 4'h0, eee = 4'h0, lpi = 4'h0;
  logic [11:0] mode = 12'h000;
  logic        sq = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  act_p = 2'h0, act_t = 2'h0;
  wire logic   awready, wready, bvalid, arready, rvalid, out;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0]  sd_clk, cu_rx, cu_tx;
  int          err_total = 0;
  int          checked = 0;
  always #2 clk = ~clk;
  rco_phy_model phy (.clk(clk), .port(act_p), .kind(act_t), .serdes_clk(sd_clk),
                     .copper_rx_clk(cu_rx), .copper_tx_clk(cu_tx));
  rco_top uut (.CORE_CLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SERDES_RECOVERED_CLOCK(sd_clk), .COPPER_RECOVERED_CLOCK(cu_rx), .COPPER_TRANSMIT_CLOCK(cu_tx),
    .LINK_UP(up), .LINK_STABLE(stb), .LINK_MODE(mode), .EEE_ACTIVE(eee), .LP_IDLE_RX(lpi),
    .CLOCK_SQUELCH_IN(sq), .RECOVERED_CLOCK_ONE_OUTPUT(out));
////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // called just after a rising edge; every bus signal moves by non-blocking assignment
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    r = bresp;
    bready <= 1'b0;
    // one edge between transfers, so a following call never re-drives a signal in this time step
    @(posedge clk);
    if (n >= 200) err_total++;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
    if (n >= 200) err_total++;
  endtask
  // whether the selected port's state lets the clock through
  function automatic logic exp_on(input logic [15:0] c, input logic u, s, input logic [2:0] m,
                                  input logic e, l, q);
    logic ok;
    ok = c[15] && c[14:11] <= 4'h3 && c[10:8] <= 3'h2 && c[2:0] <= 3'h2 && !q;
    case (c[5:4])
      2'h0: ok = ok && u && s && (m == 3'h1 || m == 3'h3) && !e;
      2'h1: ok = ok && u && s && (!e || l);
      2'h2: ok = ok && u;
      default: ok = ok;
    endcase
    return ok;
  endfunction
////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] c;
    logic [3:0]  u, s, ee, l;
    logic [11:0] m;
    logic        q, e, prev;
    int          p, tog;
    void'($urandom(20465));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CTRL, d, r);
    chk(d, 32'h0000_0000);
    rd(12'h100, d, r);
    chk({30'h0, r}, 32'h0000_0002);
    wr(CTRL, 32'hffff_ffff, r);
    chk({30'h0, r}, 32'h0000_0000);
    rd(CTRL, d, r);
    chk(d, 32'h0000_ff37);
    wstrb <= 4'h2;
    wr(CTRL, 32'h0000_0000, r);
    wstrb <= 4'hf;
    rd(CTRL, d, r);
    chk(d, 32'h0000_0037);
    wr(12'h100, 32'h0000_0000, r);
    chk({30'h0, r}, 32'h0000_0002);
    $display("register test done");
    for (int i = 0; i < 60; i++) begin
      c = 16'($urandom);
      c[15] = ($urandom % 4) != 0;
      c[14:11] = 4'($urandom % 5);
      c[10:8] = 3'($urandom % 4);
      c[2:0] = 3'($urandom % 4);
      u = 4'($urandom);
      s = 4'($urandom | $urandom);
      ee = 4'($urandom);
      l = 4'($urandom);
      m = 12'($urandom) & 12'h6db;
      q = ($urandom % 6) == 0;
      p = int'(c[12:11]);
      up <= u;
      stb <= s;
      eee <= ee;
      lpi <= l;
      mode <= m;
      sq <= q;
      act_p <= c[12:11];
      act_t <= c[1:0];
      wr(CTRL, {16'h0000, c}, r);
      e = exp_on(c, u[p], s[p], m[3*p+:3], ee[p], l[p], q);
      repeat (16) @(posedge clk);
      tog = 0;
      prev = out;
      repeat (48) begin
        @(posedge clk);
        if (out !== prev) tog++;
        prev = out;
      end
      chk({31'h0, (tog != 0 || out !== 1'b0)}, {31'h0, e});
      rd(rco_pkg::STAT_BYTE_ADDR, d, r);
      chk(d, {29'h0, q, (c[14:11] <= 4'h3 && c[10:8] <= 3'h2 && c[2:0] <= 3'h2), e});
      $display("gating test %0d ctrl=%h done", i, c);
    end
    stop_test();
  end
  initial begin
    #200us;
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
